/* hdl/lft_page_access.sv */
`include "lft_defines.svh"
`default_nettype none
module lft_page_access #(
	parameter int        HIGH_BIT_THRESHOLD_CYC =
		(`LFT_HIGH_BIT_THRESHOLD_NS * `LFT_CLK_MHZ + 999) / 1000,
	parameter int        IDLE_GAP_CYC =
		(`LFT_IDLE_GAP_NS * `LFT_CLK_MHZ) / 1000,
	parameter logic [7:0]  MFR_CODE      = 8'h5A,     // Arbitrary value
	parameter logic [23:0] SERIAL_NUMBER = 24'h000001 // Arbitrary value
) (
	input  wire logic          clk_i,                  // Recovered clock
	input  wire logic          reset_n_i,              // Async reset
	input  wire logic          end_of_burst_detect_i,  // Downlink edges
	input  wire logic          rf_field_present_i,     // Field detect
	input  wire logic          push_button_i,          // Wake input
	input  wire logic          mcu_power_down_i,       // Power-down pulse
	input  wire logic          mcu_result_valid_i,     // Result pulse
	input  wire lft_pkg::lft_word_t mcu_result_i,      // MCU result
	input  wire logic          spi_prog_i,             // SPI program pulse
	input  wire logic [5:0]    spi_page_i,             // SPI page
	input  wire logic [31:0]   spi_data_i,             // SPI data
	output logic               switched_mcu_supply_o,  // MCU supply on
	output logic               control_unit_supply_switch_o, // CU on
	output logic               mcu_rx_valid_o,         // Data for MCU
	output lft_pkg::lft_word_t mcu_rx_data_o,          // Pass-through data
	output logic               resp_valid_o,           // Uplink pulse
	output lft_pkg::lft_word_t resp_data_o,            // Uplink data
	output logic               resp_lock_o,            // Page lock status
	output logic               sel_mode_o              // Selective mode
);
	import lft_pkg::*;

	logic                  bit_valid, bit_value, frame_idle;
	logic [63:0]           frame_reg;
	logic [6:0]            bit_cnt_reg, exp_len;
	logic [7:0]            sel_addr_reg, key_reg, sel_rx;
	logic [31:0]           user_mem [`LFT_USER_SLOTS];
	logic [`LFT_SLOTS-1:0] lock_vec, prot_vec, lock_set, prot_set, lock_cell;
	logic [1:0]            cmd;
	logic [5:0]            page;
	logic [4:0]            slot, spi_slot, ans_slot_reg;
	logic [31:0]           data_rx;
	logic                  slot_ok, special, is_pt, sel_mode, carries_sel;
	logic                  sel_ok, exec, cur_lock, cur_prot, ans_pend_reg;
	logic                  do_read, do_prog, prog_answer, do_lock, do_prot;
	logic                  do_pt, spi_ok;
	lft_pwr_state_t        state_reg, state_next;
	lft_word_t             pt_result_reg;

	// Page number to storage slot: 1-3, 8-15, 40-55
	function automatic logic [4:0] page_slot(input logic [5:0] pg);
		if (pg >= 6'h01 && pg <= 6'h03)
			return 5'(pg - 6'h01);
		else if (pg >= 6'h08 && pg <= 6'h0F)
			return 5'(pg - 6'h05);
		else if (pg >= 6'h28 && pg <= 6'h37)
			return 5'(pg - 6'h1D);
		else
			return `LFT_NO_SLOT;
	endfunction

	lft_pulse_decoder #(
		.THRESH_CYC (HIGH_BIT_THRESHOLD_CYC),
		.IDLE_CYC   (IDLE_GAP_CYC)
	) u_decoder (
		.clk_i       (clk_i),
		.reset_n_i   (reset_n_i),
		.eob_i       (end_of_burst_detect_i),
		.bit_valid_o (bit_valid),
		.bit_value_o (bit_value),
		.idle_o      (frame_idle)
	);

	// Frame fields; command bits arrive first, in the low positions
	assign cmd     = frame_reg[1:0];
	assign page    = frame_reg[7:2];
	assign slot    = page_slot(page);
	assign slot_ok = slot != `LFT_NO_SLOT;
	assign special = slot_ok && slot < `LFT_SPECIAL_SLOTS;
	assign is_pt   = cmd == `LFT_CMD_PROG && page == `LFT_PT_PAGE;
	assign sel_mode   = sel_addr_reg != `LFT_SEL_GENERAL;
	assign sel_mode_o = sel_mode;
	assign sel_rx     = frame_reg[15:8];
	assign data_rx = carries_sel ? frame_reg[47:16] : frame_reg[39:8];

	// Selective address field present for selective reads, and for
	// program, lock, protect while selective mode is active
	assign carries_sel = (cmd == `LFT_CMD_SELRD_PROT && special)
		|| (sel_mode && cmd != `LFT_CMD_READ && slot_ok);
	assign exp_len = `LFT_ADDR_BITS
		+ (carries_sel ? `LFT_SEL_BITS : 7'h00)
		+ (cmd != `LFT_CMD_PROG ? 7'h00
			: (is_pt ? `LFT_PT_BITS : `LFT_DATA_BITS));
	assign exec = bit_cnt_reg >= `LFT_ADDR_BITS && bit_cnt_reg == exp_len;

	// Comparison only when stored address is not all ones
	assign sel_ok = !sel_mode || !carries_sel
		|| sel_rx == sel_addr_reg;
	assign cur_lock = slot_ok && lock_vec[slot];
	assign cur_prot = slot_ok && prot_vec[slot];

	// Command decode at frame end
	assign do_read = exec && slot_ok && (cmd == `LFT_CMD_READ
		|| (cmd == `LFT_CMD_SELRD_PROT && special && sel_ok));
	assign prog_answer = exec && slot_ok && cmd == `LFT_CMD_PROG
		&& sel_ok && !cur_prot;
	assign do_prog = prog_answer && !cur_lock;
	assign do_lock = exec && slot_ok && cmd == `LFT_CMD_LOCK && sel_ok;
	assign do_prot = exec && slot_ok && !special
		&& cmd == `LFT_CMD_SELRD_PROT && sel_ok;
	assign do_pt = exec && is_pt && (state_reg == ST_SLEEP
		|| state_reg == ST_AWAKE);
	assign spi_slot = page_slot(spi_page_i);
	assign spi_ok = spi_prog_i && spi_slot != `LFT_NO_SLOT
		&& spi_slot >= `LFT_SPECIAL_SLOTS && !lock_vec[spi_slot];

	// Bit collection; a quiet link or a finished frame restarts it
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			frame_reg   <= '0;
			bit_cnt_reg <= '0;
		end
		else if (frame_idle || exec)
		begin
			frame_reg   <= '0;
			bit_cnt_reg <= '0;
		end
		else if (bit_valid && bit_cnt_reg < 7'h40)
		begin
			frame_reg[bit_cnt_reg[5:0]] <= bit_value;
			bit_cnt_reg <= bit_cnt_reg + 7'h01;
		end
	end

	// Lock and protect bits, one irreversible cell per page
	generate
		for (genvar i = 0; i < `LFT_SLOTS; i++)
		begin : g_bits
			assign lock_set[i] = do_lock && slot == 5'(i);
			assign prot_set[i] = do_prot && slot == 5'(i);
			lft_irrev_bit u_lock (
				.clk_i     (clk_i),
				.reset_n_i (reset_n_i),
				.set_i     (lock_set[i]),
				.q_o       (lock_cell[i])
			);
			lft_irrev_bit u_prot (
				.clk_i     (clk_i),
				.reset_n_i (reset_n_i),
				.set_i     (prot_set[i]),
				.q_o       (prot_vec[i])
			);
		end
	endgenerate

	// Identity page reads as locked from manufacture on
	assign lock_vec = lock_cell | `LFT_IDENT_LOCK;

	// Special page storage; page 1 write of all ones ends selective mode
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			sel_addr_reg <= `LFT_SEL_GENERAL;
			key_reg      <= `LFT_KEY_RESET;
		end
		else if (do_prog && slot == 5'h00)
			sel_addr_reg <= data_rx[7:0];
		else if (do_prog && slot == 5'h01)
			key_reg <= data_rx[7:0];
	end

	// User pages; LF program wins over SPI in the same cycle
	always_ff @(posedge clk_i)
	begin
		if (do_prog && !special)
			user_mem[slot - `LFT_SPECIAL_SLOTS] <= data_rx;
		else if (spi_ok)
			user_mem[spi_slot - `LFT_SPECIAL_SLOTS] <= spi_data_i;
	end

	// Answer is built one cycle after the command so it shows new state
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			ans_pend_reg <= 1'b0;
			ans_slot_reg <= '0;
		end
		else
		begin
			ans_pend_reg <= do_read || prog_answer || do_lock || do_prot;
			ans_slot_reg <= slot;
		end
	end

	// Power sequencing
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_SLEEP:
				if (do_pt)
					state_next = ST_PT_MCU;
				else if (push_button_i)
					state_next = ST_AWAKE;
			ST_AWAKE:
				if (do_pt)
					state_next = ST_PT_MCU;
				else if (mcu_power_down_i)
					state_next = ST_SLEEP;
			ST_PT_MCU:
				if (mcu_result_valid_i)
					state_next = ST_PT_FIELD;
			ST_PT_FIELD:
				if (!rf_field_present_i)
					state_next = ST_PT_SEND;
			default: // Send state and stray codes
				state_next = ST_SLEEP;
		endcase
	end

	// State and supply switches
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state_reg                    <= ST_SLEEP;
			switched_mcu_supply_o        <= 1'b0;
			control_unit_supply_switch_o <= 1'b0;
		end
		else
		begin
			state_reg             <= state_next;
			switched_mcu_supply_o <= state_next == ST_AWAKE
				|| state_next == ST_PT_MCU;
			control_unit_supply_switch_o <= state_next != ST_SLEEP;
		end
	end

	// Pass-through data towards and from the MCU
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			mcu_rx_data_o  <= '0;
			mcu_rx_valid_o <= 1'b0;
			pt_result_reg  <= '0;
		end
		else
		begin
			if (do_pt)
				mcu_rx_data_o <= frame_reg[55:8];
			mcu_rx_valid_o <= state_next == ST_PT_MCU;
			if (state_reg == ST_PT_MCU && mcu_result_valid_i)
				pt_result_reg <= mcu_result_i;
		end
	end

	// Uplink answer
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			resp_valid_o <= 1'b0;
			resp_data_o  <= '0;
			resp_lock_o  <= 1'b0;
		end
		else if (ans_pend_reg)
		begin
			resp_valid_o <= 1'b1;
			resp_lock_o  <= lock_vec[ans_slot_reg];
			if (ans_slot_reg < `LFT_SPECIAL_SLOTS)
				resp_data_o <= {SERIAL_NUMBER, MFR_CODE,
					key_reg, sel_addr_reg};
			else
				resp_data_o <= {16'h0000,
					user_mem[ans_slot_reg - `LFT_SPECIAL_SLOTS]};
		end
		else if (state_reg == ST_PT_SEND)
		begin
			resp_valid_o <= 1'b1;
			resp_lock_o  <= 1'b0;
			resp_data_o  <= pt_result_reg;
		end
		else
			resp_valid_o <= 1'b0;
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	sequence seq_field_lost;
		state_reg == ST_PT_FIELD && !rf_field_present_i;
	endsequence

	chk_wake_push: assert property (
		state_reg == ST_SLEEP && push_button_i && !do_pt
		|=> switched_mcu_supply_o && control_unit_supply_switch_o)
		else $error("push did not wake");
	chk_power_down: assert property (
		state_reg == ST_AWAKE && mcu_power_down_i && !do_pt
		|=> !switched_mcu_supply_o && state_reg == ST_SLEEP)
		else $error("power-down ignored");
	chk_pt_start: assert property (
		do_pt |=> switched_mcu_supply_o && mcu_rx_valid_o)
		else $error("pass-through did not power MCU");
	chk_pt_return: assert property (
		seq_field_lost |=> ##1 resp_valid_o && state_reg == ST_SLEEP
			&& resp_data_o == pt_result_reg)
		else $error("pass-through result not sent");
	chk_lock_sticky: assert property (
		1'b1 |=> (lock_vec & $past(lock_vec)) == $past(lock_vec))
		else $error("lock bit cleared");
	chk_key_locked: assert property (
		exec && cmd == `LFT_CMD_PROG && slot == 5'h01 && cur_lock
		|=> $stable(key_reg))
		else $error("locked key page changed");
	chk_prot_silent: assert property (
		exec && cmd == `LFT_CMD_PROG && cur_prot
		|=> !ans_pend_reg ##1 !resp_valid_o)
		else $error("protected program answered");
	chk_sel_drop: assert property (
		exec && sel_mode && carries_sel && sel_rx != sel_addr_reg
		|=> !ans_pend_reg && $stable(lock_vec) && $stable(sel_addr_reg))
		else $error("mismatched command acted");
	chk_read_triple: assert property (
		ans_pend_reg && ans_slot_reg < `LFT_SPECIAL_SLOTS
		|=> resp_data_o == {SERIAL_NUMBER, MFR_CODE,
			$past(key_reg), $past(sel_addr_reg)}
			&& resp_lock_o == $past(lock_vec[ans_slot_reg]))
		else $error("special page read wrong");

endmodule // lft_page_access
`default_nettype wire

/* hdl/lft_defines.svh */
`ifndef LFT_DEFINES_SVH
`define LFT_DEFINES_SVH
// How it works
// - Reads of pages 1-3 return selective address, key page and identity
// - Lock status returned is that of the addressed page only
// - Key page holds eight bits and a lock; program only while unlocked
// - Lock command sets a page lock until reset; locked pages refuse programs
// - Identity page: fixed 8-bit maker code and 24-bit serial number
// - User storage is pages 8-15 and pages 40-55
// - Asleep only the wake flop lives; push high wakes and powers the MCU
// - MCU power-down clears the wake flop and cuts the MCU supply
// - Pass-through command powers up and waits for the MCU result
// - After result, supply off, wait field loss, send result, then sleep
// - Selective address all ones means general addressing, else selective
// - Selective mode: lock, protect, program carry the selective address
// - General reads work on all pages; selective reads on pages 1-3
// - Selective program of page 1 with all ones restores general mode
// - Protect bit on user pages 8-15, 40-55; reprogram only over SPI
// - No answer at all to an LF program of a protected page
// - Bit is one when edge-to-edge gap reaches the threshold, else zero
// - Stored address other than all ones is compared with received one
// - Command byte: two command bits first, then six page bits

`define LFT_CLK_MHZ               100
`define LFT_HIGH_BIT_THRESHOLD_NS 200000
`define LFT_IDLE_GAP_NS           2000000
`define LFT_SEL_GENERAL           8'hFF
`define LFT_KEY_RESET             8'h00
`define LFT_PT_PAGE               6'h3F
`define LFT_CMD_READ              2'h0
`define LFT_CMD_PROG              2'h1
`define LFT_CMD_LOCK              2'h2
`define LFT_CMD_SELRD_PROT        2'h3
`define LFT_ADDR_BITS             7'h08
`define LFT_SEL_BITS              7'h08
`define LFT_DATA_BITS             7'h20
`define LFT_PT_BITS               7'h30
`define LFT_SLOTS                 27
`define LFT_USER_SLOTS            24
`define LFT_SPECIAL_SLOTS         5'h03
`define LFT_NO_SLOT               5'h1F
`define LFT_IDENT_LOCK            27'h0000004
`define LFT_GAP_W                 21

`endif

/* hdl/lft_pkg.sv */
`default_nettype none
package lft_pkg;

	// Power sequencing states, one-hot
	typedef enum logic [4:0] {
		ST_SLEEP    = 5'h01,
		ST_AWAKE    = 5'h02,
		ST_PT_MCU   = 5'h04,
		ST_PT_FIELD = 5'h08,
		ST_PT_SEND  = 5'h10
	} lft_pwr_state_t;

	typedef logic [47:0] lft_word_t;

endpackage
`default_nettype wire

/* hdl/lft_irrev_bit.sv */
`default_nettype none
module lft_irrev_bit (
	input  wire logic clk_i,     // System clock
	input  wire logic reset_n_i, // Async reset, active low
	input  wire logic set_i,     // Set request
	output logic      q_o        // Bit state, cleared only by reset once set
);
	import lft_pkg::*;

	// Set only; reset is the one clear path
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			q_o <= 1'b0;
		else if (set_i)
			q_o <= 1'b1;
	end

endmodule // lft_irrev_bit
`default_nettype wire

/* hdl/lft_pulse_decoder.sv */
`default_nettype none
module lft_pulse_decoder #(
	parameter int THRESH_CYC = 20000, // Gap for a one, in cycles
	parameter int IDLE_CYC   = 200000 // Gap that ends a frame
) (
	input  wire logic clk_i,       // System clock
	input  wire logic reset_n_i,   // Async reset, active low
	input  wire logic eob_i,       // End-of-burst detector level
	output logic      bit_valid_o, // One-cycle pulse per bit
	output logic      bit_value_o, // Decoded bit
	output logic      idle_o       // Pulse when the link goes quiet
);
	import lft_pkg::*;

	localparam logic [`LFT_GAP_W-1:0] THRESH = `LFT_GAP_W'(THRESH_CYC);
	localparam logic [`LFT_GAP_W-1:0] IDLE   = `LFT_GAP_W'(IDLE_CYC);

	logic                  eob_prev_reg;
	logic                  armed_reg;
	logic [`LFT_GAP_W-1:0] gap_reg;
	logic                  rise;

	assign rise = eob_i && !eob_prev_reg;

	// Edge history
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			eob_prev_reg <= 1'b0;
		else
			eob_prev_reg <= eob_i;
	end

	// Gap counter between rising edges, saturates at the idle limit
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			gap_reg   <= '0;
			armed_reg <= 1'b0;
		end
		else if (rise)
		begin
			gap_reg   <= `LFT_GAP_W'(1);
			armed_reg <= 1'b1;
		end
		else if (armed_reg && gap_reg >= IDLE)
			armed_reg <= 1'b0;
		else if (armed_reg)
			gap_reg <= gap_reg + `LFT_GAP_W'(1);
	end

	// Bit outputs; first edge of a frame only arms the counter
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			bit_valid_o <= 1'b0;
			bit_value_o <= 1'b0;
			idle_o      <= 1'b0;
		end
		else
		begin
			bit_valid_o <= rise && armed_reg;
			bit_value_o <= gap_reg >= THRESH;
			idle_o      <= armed_reg && !rise && gap_reg >= IDLE;
		end
	end

endmodule // lft_pulse_decoder
`default_nettype wire

/* testbench/lft_reader_model.sv */
`default_nettype none
module lft_reader_model #(
	parameter int THRESH_CYC = 20 // Gap that reads as a one
) (
	input  wire logic clk_i,  // System clock
	output logic      eob_o,  // End-of-burst edges
	output logic      field_o // Carrier on
);
	timeunit 1ns;
	timeprecision 1ps;

	// Link quiet and carrier off at start
	initial
	begin
		eob_o = 1'b0;
		field_o = 1'b0;
	end

	// Carrier switch, left on through whole accesses and bursts
	task automatic set_field(input logic on);
		@(posedge clk_i);
		field_o <= on;
	endtask

	// Arming edge, then one edge per bit; slow stretches high bits
	task automatic send(input logic [95:0] v, input int n, input int slow);
		int gap;
		@(posedge clk_i);
		eob_o <= 1'b1;
		for (int i = 0; i < n; i++)
		begin
			gap = v[i] ? THRESH_CYC + slow : THRESH_CYC - 1;
			@(posedge clk_i);
			eob_o <= 1'b0;
			repeat (gap - 1) @(posedge clk_i);
			eob_o <= 1'b1;
		end
		@(posedge clk_i);
		eob_o <= 1'b0;
	endtask
endmodule // lft_reader_model
`default_nettype wire

/* testbench/lft_page_access_tb.sv */
`default_nettype none
module lft_page_access_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import lft_pkg::*;

	localparam int          TH   = 20;
	localparam int          IDLE = 200;
	localparam logic [7:0]  MFR  = 8'h3D;     // Arbitrary value
	localparam logic [23:0] SER  = 24'h00C0DE; // Arbitrary value
	localparam logic [31:0] D1   = 32'h1234ABCD;
	localparam logic [31:0] D2   = 32'hC0FFEE01;
	localparam logic [31:0] KA   = 32'hA5A5A5A5;
	localparam logic [31:0] SA   = 32'h3C3C3C3C;
	localparam lft_word_t   PT   = 48'h0123456789AB;
	localparam lft_word_t   RS   = 48'hFEDCBA987654;

	logic        clk, rst_n, end_of_burst_detect, fld, pb, pd, rv, sp;
	logic [5:0]  s_pg;
	logic [31:0] s_dt;
	lft_word_t   mres, rx_d, r_d, last_d;
	logic        sw, cu, rx_v, r_v, r_lk, sel, last_lk;
	int          err_total, checks, n_resp;

	// Input defaults and clock
	initial
	begin
		{rst_n, pb, pd, rv, sp, s_pg, s_dt, mres} = '0;
		err_total = 0;
		checks = 0;
		n_resp = 0;
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	lft_page_access #(
		.HIGH_BIT_THRESHOLD_CYC (TH),
		.IDLE_GAP_CYC           (IDLE),
		.MFR_CODE               (MFR),
		.SERIAL_NUMBER          (SER)
	) u_lft_page_access (
		.clk_i                        (clk),
		.reset_n_i                    (rst_n),
		.end_of_burst_detect_i        (end_of_burst_detect),
		.rf_field_present_i           (fld),
		.push_button_i                (pb),
		.mcu_power_down_i             (pd),
		.mcu_result_valid_i           (rv),
		.mcu_result_i                 (mres),
		.spi_prog_i                   (sp),
		.spi_page_i                   (s_pg),
		.spi_data_i                   (s_dt),
		.switched_mcu_supply_o        (sw),
		.control_unit_supply_switch_o (cu),
		.mcu_rx_valid_o               (rx_v),
		.mcu_rx_data_o                (rx_d),
		.resp_valid_o                 (r_v),
		.resp_data_o                  (r_d),
		.resp_lock_o                  (r_lk),
		.sel_mode_o                   (sel)
	);

	lft_reader_model #(
		.THRESH_CYC (TH)
	) u_lft_reader_model (
		.clk_i   (clk),
		.eob_o   (end_of_burst_detect),
		.field_o (fld)
	);

	// Tally uplink answers
	always @(posedge clk)
		if (r_v === 1'b1)
		begin
			n_resp <= n_resp + 1;
			last_d <= r_d;
			last_lk <= r_lk;
		end

	// Comparison, verdict and expected special-page word
	task automatic chk(input string nm, input lft_word_t e, input lft_word_t g);
		checks++;
		if (g !== e)
		begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	function automatic lft_word_t spw(input logic [7:0] k, input logic [7:0] s);
		return {SER, MFR, k, s};
	endfunction

	// One downlink frame, LSB first, then count the answers
	task automatic frame(input logic [1:0] c, input logic [5:0] pg,
		input logic hs, input logic [7:0] sa, input int nd,
		input lft_word_t d, input logic ans);
		logic [95:0] v;
		int          n;
		int          n0;
		v = 96'h0;
		v[7:0] = {pg, c};
		n = 8;
		if (hs)
		begin
			v[15:8] = sa;
			n = 16;
		end
		for (int i = 0; i < nd; i++)
			v[n + i] = d[i];
		n0 = n_resp;
		u_lft_reader_model.send(v, n + nd, n0 % 3);
		repeat (10) @(posedge clk);
		#1;
		chk("answer count", 48'(ans), 48'(n_resp - n0));
		repeat (IDLE + 20) @(posedge clk);
	endtask

	task automatic rd(input logic [5:0] pg, input lft_word_t e, input logic lk);
		frame(2'h0, pg, 1'b0, 8'h00, 0, 48'h0, 1'b1);
		chk("read data", e, last_d);
		chk("read lock", 48'(lk), 48'(last_lk));
	endtask

	// One SPI program pulse
	task automatic spi_wr(input logic [5:0] pg, input logic [31:0] d);
		@(posedge clk);
		sp <= 1'b1;
		s_pg <= pg;
		s_dt <= d;
		@(posedge clk);
		sp <= 1'b0;
	endtask

	task automatic prog(input logic [5:0] pg, input logic [31:0] d,
		input logic ans);
		frame(2'h1, pg, 1'b0, 8'h00, 32, {16'h0, d}, ans);
	endtask

	// Scenarios
	task automatic t_special();
		chk("idle outputs", 48'h0, 48'({sw, cu, rx_v, r_v, sel}));
		for (int p = 1; p <= 3; p++)
			rd(6'(p), spw(8'h00, 8'hFF), p == 3);
		$display("special pages done");
	endtask

	task automatic t_user();
		prog(6'h08, D1, 1'b1);
		rd(6'h08, {16'h0, D1}, 1'b0);
		prog(6'h37, D2, 1'b1);
		rd(6'h37, {16'h0, D2}, 1'b0);
		prog(6'h28, D1, 1'b1);
		prog(6'h04, D2, 1'b0);
		prog(6'h10, D2, 1'b0);
		prog(6'h27, D2, 1'b0);
		prog(6'h09, D1, 1'b1);
		frame(2'h2, 6'h09, 1'b0, 8'h00, 0, 48'h0, 1'b1);
		prog(6'h09, D2, 1'b1);
		chk("locked answer", {16'h0, D1}, last_d);
		rd(6'h09, {16'h0, D1}, 1'b1);
		$display("user pages done");
	endtask

	task automatic t_key();
		prog(6'h02, KA, 1'b1);
		rd(6'h02, spw(8'hA5, 8'hFF), 1'b0);
		frame(2'h2, 6'h02, 1'b0, 8'h00, 0, 48'h0, 1'b1);
		prog(6'h02, SA, 1'b1);
		rd(6'h02, spw(8'hA5, 8'hFF), 1'b1);
		rd(6'h01, spw(8'hA5, 8'hFF), 1'b0);
		$display("key page done");
	endtask

	task automatic t_protect();
		prog(6'h0A, D1, 1'b1);
		frame(2'h3, 6'h0A, 1'b0, 8'h00, 0, 48'h0, 1'b1);
		prog(6'h0A, D2, 1'b0);
		rd(6'h0A, {16'h0, D1}, 1'b0);
		spi_wr(6'h0A, D2);
		rd(6'h0A, {16'h0, D2}, 1'b0);
		spi_wr(6'h09, D2);
		rd(6'h09, {16'h0, D1}, 1'b1);
		$display("protection done");
	endtask

	task automatic t_select();
		prog(6'h01, SA, 1'b1);
		chk("selective mode", 48'h1, 48'(sel));
		frame(2'h1, 6'h08, 1'b1, 8'h3C, 32, {16'h0, D2}, 1'b1);
		frame(2'h1, 6'h08, 1'b1, 8'h3D, 32, {16'h0, D1}, 1'b0);
		rd(6'h08, {16'h0, D2}, 1'b0);
		frame(2'h3, 6'h01, 1'b1, 8'h3C, 0, 48'h0, 1'b1);
		chk("selective read", spw(8'hA5, 8'h3C), last_d);
		frame(2'h1, 6'h01, 1'b1, 8'h3C, 32, 48'hFFFFFFFF, 1'b1);
		chk("general mode", 48'h0, 48'(sel));
		$display("addressing done");
	endtask

	task automatic t_power();
		@(posedge clk);
		pb <= 1'b1;
		@(posedge clk);
		pb <= 1'b0;
		@(posedge clk);
		#1;
		chk("supplies on", 48'h3, 48'({sw, cu}));
		@(posedge clk);
		pd <= 1'b1;
		@(posedge clk);
		pd <= 1'b0;
		@(posedge clk);
		#1;
		chk("supplies off", 48'h0, 48'({sw, cu}));
		$display("power done");
	endtask

	task automatic t_pass();
		int n0;
		frame(2'h1, 6'h3F, 1'b0, 8'h00, 48, PT, 1'b0);
		chk("mcu wait", 48'h7, 48'({rx_v, sw, cu}));
		chk("mcu data", PT, rx_d);
		n0 = n_resp;
		@(posedge clk);
		rv <= 1'b1;
		mres <= RS;
		@(posedge clk);
		rv <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk("mcu done", 48'h0, 48'({rx_v, sw}));
		chk("early uplink", 48'h0, 48'(n_resp - n0));
		u_lft_reader_model.set_field(1'b0);
		repeat (6) @(posedge clk);
		#1;
		chk("uplink count", 48'h1, 48'(n_resp - n0));
		chk("uplink data", RS, last_d);
		chk("unit supply off", 48'h0, 48'(cu));
		u_lft_reader_model.set_field(1'b1);
		$display("pass-through done");
	endtask

	// Watchdog
	initial
	begin
		repeat (60000) @(posedge clk);
		err_total++;
		$display("watchdog expired");
		end_of_test();
	end

	// Main sequence
	initial
	begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		u_lft_reader_model.set_field(1'b1);
		repeat (4) @(posedge clk);
		#1;
		t_special();
		t_user();
		t_key();
		t_protect();
		t_select();
		t_power();
		t_pass();
		end_of_test();
	end
endmodule // lft_page_access_tb
`default_nettype wire
